// *** core/arb_params.svh ***
// Summary of operation
// - Mode 0: bus request driven high
// - Modes 1-3: bus request driven low
// - Mode 0: high grant permits taking bus
// - Modes 1-3: low grant permits taking bus
// - Grant lost: release at cycle boundary
// - Unused grant passes down chain low
// - Wait for busy high before taking
// - Hold busy low while owning bus
// - Drive busy high, then release line
// - Mode inputs decode as two-bit value
// - Interrupt pending drives open-drain low
// - Low acknowledge input means acknowledge cycle
`ifndef ARB_PARAMS_SVH
`define ARB_PARAMS_SVH
`define MODE_HIGH_ACTIVE 2'h0
`define MODE_W           2
`endif

// *** core/arb_pkg.sv ***
package arb_pkg;
   typedef enum logic [3:0] {
      ST_IDLE = 4'h1,
      ST_WAIT = 4'h2,
      ST_OWN  = 4'h4,
      ST_END  = 4'h8
   } arb_state_t;
endpackage : arb_pkg

// *** core/host_bus_arbiter.sv ***
`timescale 1ns/1ps
`include "arb_params.svh"
module host_bus_arbiter (
   // Clock and reset
   input  wire logic clk_sys,
   input  wire logic rst,
   input  wire logic clk_en,
   // Mode straps
   input  wire logic mode_select_lsb,
   input  wire logic mode_select_msb,
   // DMA side
   input  wire logic dma_req,
   input  wire logic dma_cycle_end,
   output logic      dma_granted,
   // Host arbitration pins
   output logic      bus_request_out,
   input  wire logic bus_grant_in,
   output logic      chain_enable_out,
   // Shared busy line, open drain
   input  wire logic busy_in_n,
   output logic      busy_out,
   output logic      busy_oe,
   // Interrupt pins
   input  wire logic irq_pending,
   output logic      irq_out,
   output logic      irq_oe,
   input  wire logic irq_ack_in_n,
   output logic      irq_ack_cycle
);
   ////////////////////////////////////////////////////////////////////
   logic [`MODE_W-1:0]   mode_r;
   logic                 mode_valid_r;
   arb_pkg::arb_state_t  state_r;
   arb_pkg::arb_state_t  state_nxt;
   logic                 grant_ok;
   logic                 high_mode;
   logic                 strap_high;
   logic                 request_nxt;
   logic                 busy_out_nxt;
   logic                 busy_oe_nxt;
   logic                 granted_nxt;
   logic                 chain_nxt;

   // Straps follow the pins while reset is held, so the handshake
   // levels are right from the first edge after release
   // Later strap changes are not supported
   // Two-bit mode decode
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         mode_valid_r <= 1'b0;
         mode_r       <= {mode_select_msb, mode_select_lsb};
      end else if (clk_en && !mode_valid_r) begin
         mode_valid_r <= 1'b1;
         mode_r       <= {mode_select_msb, mode_select_lsb};
      end
   end

   // Only mode 0 uses active-high handshakes
   always_comb begin
      case (mode_r)
         `MODE_HIGH_ACTIVE: begin
            high_mode = 1'b1;
         end
         default: begin
            high_mode = 1'b0;
         end
      endcase
   end

   // Live strap level, used only for the request pin during reset
   assign strap_high = ({mode_select_msb, mode_select_lsb} ==
                        `MODE_HIGH_ACTIVE);

   assign grant_ok  = high_mode ? bus_grant_in : ~bus_grant_in;

   ////////////////////////////////////////////////////////////////////
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         arb_pkg::ST_IDLE: begin
            if (dma_req && mode_valid_r) begin
               state_nxt = arb_pkg::ST_WAIT;
            end
         end
         arb_pkg::ST_WAIT: begin
            if (!dma_req) begin
               state_nxt = arb_pkg::ST_IDLE;
            end else if (grant_ok && busy_in_n) begin
               state_nxt = arb_pkg::ST_OWN;
            end
         end
         arb_pkg::ST_OWN: begin
            if (dma_cycle_end && (!grant_ok || !dma_req)) begin
               state_nxt = arb_pkg::ST_END;
            end
         end
         arb_pkg::ST_END: begin
            state_nxt = arb_pkg::ST_IDLE;
         end
         default: begin
            state_nxt = arb_pkg::ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         state_r <= arb_pkg::ST_IDLE;
      end else if (clk_en) begin
         state_r <= state_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Pin levels are decoded from the next state so that the pins and
   // the state register change on the same edge
   always_comb begin
      request_nxt  = 1'b0;
      busy_out_nxt = 1'b1;
      busy_oe_nxt  = 1'b0;
      granted_nxt  = 1'b0;
      case (state_nxt)
         arb_pkg::ST_IDLE: begin
            request_nxt = 1'b0;
         end
         arb_pkg::ST_WAIT: begin
            request_nxt = 1'b1;
         end
         arb_pkg::ST_OWN: begin
            request_nxt  = 1'b1;
            busy_out_nxt = 1'b0;
            busy_oe_nxt  = 1'b1;
            granted_nxt  = 1'b1;
         end
         // Busy driven high for one cycle before the line is let go
         arb_pkg::ST_END: begin
            busy_oe_nxt = 1'b1;
         end
         default: begin
            request_nxt = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         bus_request_out <= ~strap_high;
      end else if (clk_en) begin
         if (request_nxt) begin
            bus_request_out <= high_mode;
         end else begin
            bus_request_out <= ~high_mode;
         end
      end
   end

   // Grant is handed on only from idle: once a transfer has started,
   // passing it down could put two masters on the bus
   // Pass unused grant down
   assign chain_nxt = mode_valid_r && grant_ok && !dma_req &&
                      (state_r == arb_pkg::ST_IDLE);

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         chain_enable_out <= 1'b1;
      end else if (clk_en) begin
         chain_enable_out <= ~chain_nxt;
      end
   end

   // Busy low while owner, high pulse on release
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         busy_out    <= 1'b1;
         busy_oe     <= 1'b0;
         dma_granted <= 1'b0;
      end else if (clk_en) begin
         busy_out    <= busy_out_nxt;
         busy_oe     <= busy_oe_nxt;
         dma_granted <= granted_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Interrupt request and acknowledge
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         irq_out       <= 1'b0;
         irq_oe        <= 1'b0;
         irq_ack_cycle <= 1'b0;
      end else if (clk_en) begin
         irq_out       <= 1'b0;
         irq_oe        <= irq_pending;
         irq_ack_cycle <= ~irq_ack_in_n;
      end
   end
endmodule : host_bus_arbiter

// *** verif/host_bus_arbiter_asserts.sv ***
`timescale 1ns/1ps
module host_bus_arbiter_asserts (
   input wire logic clk_sys, rst, mode_select_lsb, mode_select_msb,
   input wire logic dma_req, dma_cycle_end, dma_granted, bus_request_out,
   input wire logic bus_grant_in, chain_enable_out, busy_in_n, busy_out,
   input wire logic busy_oe, irq_pending, irq_out, irq_oe, irq_ack_in_n,
   input wire logic irq_ack_cycle
);
   // Straps stay fixed, so the live value is the latched mode
   wire m0 = !mode_select_msb && !mode_select_lsb;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   sequence s_rel; busy_oe && busy_out ##1 !busy_oe; endsequence
   AST_OWN: assert property (
      dma_granted |-> busy_oe && !busy_out) else $error("busy not low");
   AST_TAKE: assert property (
      $rose(dma_granted) |-> $past(busy_in_n) && $past(bus_grant_in) == m0)
      else $error("bus taken wrongly");
   AST_REQ: assert property (
      dma_granted |-> bus_request_out == m0) else $error("request level");
   AST_REL: assert property (
      $fell(dma_granted) |-> s_rel) else $error("bad busy release");
   AST_END: assert property (
      $fell(dma_granted) |-> $past(dma_cycle_end)) else $error("early drop");
   AST_CHAIN: assert property (
      !chain_enable_out |-> $past(bus_grant_in) == m0 && !$past(dma_req))
      else $error("chain passed wrongly");
   AST_IRQ: assert property (
      irq_oe == $past(irq_pending) && !irq_out) else $error("irq pin");
   AST_ACK: assert property (
      irq_ack_cycle == !$past(irq_ack_in_n)) else $error("ack cycle");
endmodule : host_bus_arbiter_asserts
bind host_bus_arbiter host_bus_arbiter_asserts chk_i (.*);

// *** verif/host_model.sv ***
`timescale 1ns/1ps
module host_model (
   input wire logic clk_sys, m0, req, offer, deny,
   output logic     grant
);
   initial grant = 1'b1;
   always @(posedge clk_sys)
      grant <= ((req == m0 || offer) && !deny) ? m0 : !m0;
endmodule : host_model

// *** verif/tb_host_bus_arbitration_handshake.sv ***
`timescale 1ns/1ps
module tb_host_bus_arbitration_handshake;
   logic clk_sys = 0, rst = 1, msb = 0, lsb = 0, dma_req = 0, c_end = 0;
   logic pend = 0, ack_n = 1, deny = 0, offer = 0, ext = 0;
   logic owns, req, grant, chain, b_out, b_oe, i_out, i_oe, ack_c;
   wire  busy_n = !ext && !(b_oe && !b_out);
   int   errors = 0, n_compared = 0;
   always #12.5 clk_sys = ~clk_sys;
   host_model host (.clk_sys, .m0(!msb && !lsb), .req, .offer, .deny, .grant);
   host_bus_arbiter dut (.clk_sys, .rst, .clk_en(1'b1), .mode_select_lsb(lsb),
      .mode_select_msb(msb), .dma_req, .dma_cycle_end(c_end),
      .dma_granted(owns), .bus_request_out(req), .bus_grant_in(grant),
      .chain_enable_out(chain), .busy_in_n(busy_n), .busy_out(b_out),
      .busy_oe(b_oe), .irq_pending(pend), .irq_out(i_out), .irq_oe(i_oe),
      .irq_ack_in_n(ack_n), .irq_ack_cycle(ack_c));
   task automatic chk(logic g, logic e);
      n_compared++;
      if (g !== e) begin
         errors++;
         $display("wrong value at %0t: %b not %b", $time, g, e);
      end
   endtask : chk
   // Drives land on the edge; outputs read here are those of the last edge
   task automatic go(int n);
      repeat (n) @(posedge clk_sys);
   endtask : go
   task automatic t_arb(logic [1:0] m);
      logic a;
      a = (m == 2'h0);
      {msb, lsb} <= m;
      rst <= 1;
      go(2);
      rst <= 0;
      ext <= 1;
      dma_req <= 1;
      go(6);
      chk(owns, 0);
      chk(req, a);
      ext <= 0;
      go(3);
      chk(owns, 1);
      chk(busy_n, 0);
      deny <= 1;
      go(3);
      chk(owns, 1);
      c_end <= 1;
      go(1);
      c_end <= 0;
      dma_req <= 0;
      go(1);
      chk(b_oe && b_out, 1);
      chk(owns, 0);
      go(1);
      chk(b_oe, 0);
      chk(req, !a);
      deny <= 0;
   endtask : t_arb
   task automatic t_chain;
      offer <= 1;
      go(3);
      chk(chain, 0);
      dma_req <= 1;
      go(2);
      chk(chain, 1);
      dma_req <= 0;
      c_end <= 1;
      offer <= 0;
      go(4);
      chk(owns, 0);
      c_end <= 0;
   endtask : t_chain
   task automatic t_irq;
      pend <= 1;
      ack_n <= 0;
      go(2);
      chk(i_oe && !i_out, 1);
      chk(ack_c, 1);
      pend <= 0;
      ack_n <= 1;
      go(2);
      chk(i_oe || ack_c, 0);
   endtask : t_irq
   task automatic test_done;
      if (errors == 0 && n_compared > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : test_done
   initial begin
      for (int m = 0; m < 4; m++) t_arb(m[1:0]);
      t_chain();
      t_irq();
      test_done();
   end
   // Whole run needs about 80 cycles
   initial begin
      #20000;
      errors++;
      test_done();
   end
endmodule : tb_host_bus_arbitration_handshake
